// file: verilog/pplr_port_io.sv
`timescale 1ns/10ps
module pplr_port_io
    import pplr_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] pin_a_in,
    output logic [7:0] pin_a_out,
    output logic [7:0] pin_a_oe,
    input wire logic [7:0] pin_b_in,
    output logic [7:0] pin_b_out,
    output logic [7:0] pin_b_oe,
    input wire logic [7:0] pin_c_in,
    output logic [7:0] pin_c_out,
    output logic [7:0] pin_c_oe,
    input wire logic [7:0] pin_d_in,
    output logic [7:0] pin_d_out,
    output logic [7:0] pin_d_oe,
    input wire logic [7:0] gla_out_a,
    input wire logic [7:0] gla_out_b,
    input wire logic [7:0] gla_out_c,
    input wire logic [7:0] dla_cs_d,
    input wire logic [7:0] la_oe_a,
    input wire logic [7:0] la_oe_b,
    input wire logic [7:0] la_oe_c,
    input wire logic [7:0] la_oe_d,
    input wire logic [7:0] la_sel_a,
    input wire logic [7:0] la_sel_b,
    input wire logic [7:0] la_sel_c,
    input wire logic [7:0] la_sel_d,
    output logic [7:0] la_in_a,
    output logic [7:0] la_in_b,
    output logic [7:0] la_in_c,
    output logic [7:0] la_in_d
);

    logic [3:0][7:0] dout_r;
    logic [3:0][7:0] dir_r;
    logic [3:0][7:0] pin_in;
    logic [3:0][7:0] la_out;
    logic [3:0][7:0] la_oe;
    logic [3:0][7:0] la_sel;
    logic [3:0][7:0] pin_out;
    logic [3:0][7:0] pin_oe;
    logic [3:0][7:0] in_mc_r;
    logic [PPLR_IDX_W-1:0] idx;
    logic aligned;
    logic hit;
    logic [31:0] rd_nxt;
    logic [31:0] prdata_r;
    logic wr_en;
    logic setup;

    assign pin_in = {pin_d_in, pin_c_in, pin_b_in, pin_a_in};
    // port d pins come from decode chip-selects, no macrocell used
    assign la_out = {dla_cs_d, gla_out_c, gla_out_b, gla_out_a};
    assign la_oe = {la_oe_d, la_oe_c, la_oe_b, la_oe_a};
    assign la_sel = {la_sel_d, la_sel_c, la_sel_b, la_sel_a};

    assign idx = paddr[PPLR_ADDR_LSB +: PPLR_IDX_W];
    assign aligned = (paddr[PPLR_ADDR_LSB-1:0] == '0)
        && (paddr[ADDR_W-1:PPLR_ADDR_LSB+PPLR_IDX_W] == '0);
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && hit && pstrb[0];

    // read decode; pin levels sampled at setup, one word per register
    always_comb
    begin
        rd_nxt = PPLR_RD_ZERO;
        hit = 1'b0;
        for (int p = 0; p < PPLR_PORTS; p++)
        begin
            if (aligned && idx == PPLR_IN_IDX[p])
            begin
                hit = 1'b1;
                rd_nxt[7:0] = pin_in[p] & PPLR_MASK[p];
            end
            else if (aligned && idx == PPLR_OUT_IDX[p])
            begin
                hit = 1'b1;
                rd_nxt[7:0] = dout_r[p];
            end
            else if (aligned && idx == PPLR_DIR_IDX[p])
            begin
                hit = 1'b1;
                rd_nxt[7:0] = dir_r[p];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= PPLR_RD_ZERO;
        else if (setup)
            prdata_r <= rd_nxt;
    end

    // zero wait states: read data is ready by the access phase
    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    genvar g;
    generate
        for (g = 0; g < PPLR_PORTS; g++)
        begin : g_port
            // unimplemented bits never hold a one
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    dout_r[g] <= PPLR_RST_VAL;
                else if (wr_en && idx == PPLR_OUT_IDX[g])
                    dout_r[g] <= pwdata[7:0] & PPLR_MASK[g];
            end

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    dir_r[g] <= PPLR_RST_VAL;
                else if (wr_en && idx == PPLR_DIR_IDX[g])
                    dir_r[g] <= pwdata[7:0] & PPLR_MASK[g];
            end

            // unselected macrocell leaves the pin level to the output register
            assign pin_out[g] = (la_sel[g] & la_out[g])
                | (~la_sel[g] & dout_r[g]);
            // masked so debug pins and absent bits never drive
            assign pin_oe[g] = (la_oe[g] | dir_r[g])
                & PPLR_MASK[g];
        end
    endgenerate

    // input macrocells for a-c are clocked latches of the pin level
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            in_mc_r <= '0;
        else
            in_mc_r <= pin_in;
    end

    assign la_in_a = in_mc_r[0];
    assign la_in_b = in_mc_r[1];
    assign la_in_c = in_mc_r[2];
    assign la_in_d = pin_d_in;

    assign pin_a_out = pin_out[0];
    assign pin_b_out = pin_out[1];
    assign pin_c_out = pin_out[2];
    assign pin_d_out = pin_out[3];
    assign pin_a_oe = pin_oe[0];
    assign pin_b_oe = pin_oe[1];
    assign pin_c_oe = pin_oe[2];
    assign pin_d_oe = pin_oe[3];

    // helper: low only in the first cycle after reset release
    logic after_rst_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            after_rst_r <= 1'b0;
        else
            after_rst_r <= 1'b1;
    end

    sequence s_wr_b_out;
        psel && penable && pwrite && pstrb[0] && aligned
            && idx == PPLR_IDX_B_OUT;
    endsequence

    sequence s_rd_b_in;
        setup && !pwrite && aligned && idx == PPLR_IDX_B_IN;
    endsequence

    // write steps: a qualified access to one register index
    sequence s_wr_b_dir;
        psel && penable && pwrite && pstrb[0] && aligned
            && idx == PPLR_IDX_B_DIR;
    endsequence

    sequence s_wr_c_out;
        psel && penable && pwrite && pstrb[0] && aligned
            && idx == PPLR_IDX_C_OUT;
    endsequence

    sequence s_wr_d_dir;
        psel && penable && pwrite && pstrb[0] && aligned
            && idx == PPLR_IDX_D_DIR;
    endsequence

    // input words are read only, a write there must change nothing
    sequence s_wr_in_reg;
        psel && penable && pwrite && aligned
            && (idx == PPLR_IDX_A_IN || idx == PPLR_IDX_B_IN
            || idx == PPLR_IDX_C_IN || idx == PPLR_IDX_D_IN);
    endsequence

    sequence s_rd_b_out;
        setup && !pwrite && aligned && idx == PPLR_IDX_B_OUT;
    endsequence

    sequence s_rd_c_in;
        setup && !pwrite && aligned && idx == PPLR_IDX_C_IN;
    endsequence

    a_reset_regs_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        !after_rst_r |-> (dout_r == '0 && dir_r == '0))
        else $error("registers not zero after reset");

    a_reset_pins_float: assert property (
        @(posedge pclk) disable iff (!presetn)
        !after_rst_r |-> (pin_b_oe == la_oe_b))
        else $error("pin driving without enable after reset");

    a_pin_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((pin_b_out ^ dout_r[1]) & ~la_sel_b) == '0)
        else $error("pin level differs from output data");

    a_oe_or_term: assert property (
        @(posedge pclk) disable iff (!presetn)
        pin_c_oe == ((la_oe_c | dir_r[2]) & PPLR_MASK_C))
        else $error("output enable not or of term and direction");

    a_write_next_cycle: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_b_out ##1 (la_sel_b == '0)
        |-> pin_b_out == $past(pwdata[7:0]))
        else $error("write not on pin next cycle");

    a_c_unimpl_bits: assert property (
        @(posedge pclk) disable iff (!presetn)
        (dout_r[2] & ~PPLR_MASK_C) == '0)
        else $error("port c unimplemented bit set");

    a_d_unimpl_bits: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((dout_r[3] | dir_r[3]) & ~PPLR_MASK_D) == '0)
        else $error("port d unimplemented bit set");

    a_debug_pins_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        (pin_c_oe & ~PPLR_MASK_C) == '0)
        else $error("debug pin driven");

    a_array_out_wins: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((pin_c_out ^ gla_out_c) & la_sel_c) == '0)
        else $error("array output pin follows register");

    a_read_pin_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_rd_b_in |=> prdata[7:0] == $past(pin_b_in))
        else $error("input read not pin level");

    a_macrocell_delay: assert property (
        @(posedge pclk) disable iff (!presetn)
        after_rst_r |-> (la_in_b == $past(pin_b_in)
            && la_in_d == pin_d_in))
        else $error("array input routing wrong");

    a_dir_next_cycle: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_b_dir |=> pin_b_oe == ($past(pwdata[7:0]) | la_oe_b))
        else $error("direction write not on pin next cycle");

    a_c_write_mask: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_c_out |=> dout_r[2] == ($past(pwdata[7:0]) & PPLR_MASK_C))
        else $error("port c write not masked");

    a_d_dir_mask: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_d_dir |=> dir_r[3] == ($past(pwdata[7:0]) & PPLR_MASK_D))
        else $error("port d direction write not masked");

    a_in_write_ignored: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_in_reg |=> $stable(dout_r) && $stable(dir_r))
        else $error("write to input word changed a register");

    a_strobe_off_kept: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && !pstrb[0]
        |=> $stable(dout_r) && $stable(dir_r))
        else $error("write without strobe changed a register");

    a_bad_addr_kept: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && !hit
        |=> $stable(dout_r) && $stable(dir_r))
        else $error("unmapped write changed a register");

    a_in_no_error: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable && aligned && idx == PPLR_IDX_B_IN |-> !pslverr)
        else $error("input word access flagged as error");

    a_read_out_reg: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_rd_b_out |=> prdata[7:0] == $past(dout_r[1]))
        else $error("output data read back wrong");

    a_read_c_masked: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_rd_c_in |=> prdata[7:0] == ($past(pin_c_in) & PPLR_MASK_C))
        else $error("port c input read not masked");

    a_a_macrocell: assert property (
        @(posedge pclk) disable iff (!presetn)
        after_rst_r |-> (la_in_a == $past(pin_a_in)
            && la_in_c == $past(pin_c_in)))
        else $error("port a or c array input not one cycle late");

    a_d_chip_select: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((pin_d_out ^ dla_cs_d) & la_sel_d) == '0)
        else $error("port d pin not following chip select");

    a_a_array_out: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((pin_a_out ^ gla_out_a) & la_sel_a) == '0)
        else $error("port a array pin follows register");

    a_a_dir_acts: assert property (
        @(posedge pclk) disable iff (!presetn)
        pin_a_oe == ((la_oe_a | dir_r[0]) & PPLR_MASK_A))
        else $error("port a direction not acting on driver");

endmodule : pplr_port_io

// file: verilog/pplr_pkg.sv
package pplr_pkg;

    localparam int PPLR_PORTS = 4;
    localparam int PPLR_ADDR_LSB = 2;
    localparam int PPLR_IDX_W = 8;

    // register indices; byte address is four times the index
    localparam logic [7:0] PPLR_IDX_A_IN = 8'h00;
    localparam logic [7:0] PPLR_IDX_B_IN = 8'h01;
    localparam logic [7:0] PPLR_IDX_C_IN = 8'h10;
    localparam logic [7:0] PPLR_IDX_D_IN = 8'h11;
    localparam logic [7:0] PPLR_IDX_A_OUT = 8'h04;
    localparam logic [7:0] PPLR_IDX_B_OUT = 8'h05;
    localparam logic [7:0] PPLR_IDX_B_DIR = 8'h07;
    localparam logic [7:0] PPLR_IDX_C_OUT = 8'h12;
    localparam logic [7:0] PPLR_IDX_D_OUT = 8'h13;
    localparam logic [7:0] PPLR_IDX_C_DIR = 8'h14;
    localparam logic [7:0] PPLR_IDX_D_DIR = 8'h15;
    localparam logic [7:0] PPLR_IDX_A_DIR = 8'h16;

    // per-port tables, entry 0 is port a
    localparam logic [3:0][7:0] PPLR_IN_IDX =
        {PPLR_IDX_D_IN, PPLR_IDX_C_IN, PPLR_IDX_B_IN, PPLR_IDX_A_IN};
    localparam logic [3:0][7:0] PPLR_OUT_IDX =
        {PPLR_IDX_D_OUT, PPLR_IDX_C_OUT, PPLR_IDX_B_OUT, PPLR_IDX_A_OUT};
    localparam logic [3:0][7:0] PPLR_DIR_IDX =
        {PPLR_IDX_D_DIR, PPLR_IDX_C_DIR, PPLR_IDX_B_DIR, PPLR_IDX_A_DIR};

    // implemented pin bits per port
    localparam logic [7:0] PPLR_MASK_A = 8'hff;
    localparam logic [7:0] PPLR_MASK_B = 8'hff;
    localparam logic [7:0] PPLR_MASK_C = 8'h9c;
    localparam logic [7:0] PPLR_MASK_D = 8'h06;
    localparam logic [3:0][7:0] PPLR_MASK =
        {PPLR_MASK_D, PPLR_MASK_C, PPLR_MASK_B, PPLR_MASK_A};

    localparam logic [7:0] PPLR_RST_VAL = 8'h00;
    localparam logic [31:0] PPLR_RD_ZERO = 32'h00000000;

endpackage : pplr_pkg

// file: tb/pplr_pins.sv
`timescale 1ns/10ps
module pplr_pins
(
    input wire logic [31:0] drv,
    input wire logic [31:0] oe,
    input wire logic [31:0] ext,
    output logic [31:0] lvl
);
    // an undriven pin shows the outside level, never a stale drive
    assign lvl = (oe & drv) | (~oe & ext);
endmodule : pplr_pins

// file: tb/pplr_bench.sv
`timescale 1ns/10ps
module pplr_bench
    import pplr_pkg::*;
();
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [3:0] pstrb;
    logic [31:0] pwdata, prdata, rd, ext, lg, lo, ls;
    wire [31:0] lv, po, pe, li;
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [7:0] ix [7] = '{PPLR_IDX_B_OUT, PPLR_IDX_B_DIR, PPLR_IDX_C_OUT,
        PPLR_IDX_D_OUT, PPLR_IDX_C_DIR, PPLR_IDX_D_DIR, PPLR_IDX_A_DIR};
    logic [7:0] mk [7] = '{8'hff, 8'hff, 8'h9c, 8'h06, 8'h9c, 8'h06, 8'hff};
    pplr_pins pins (.drv(po), .oe(pe), .ext(ext), .lvl(lv));
    pplr_port_io uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .pin_a_in(lv[7:0]), .pin_b_in(lv[15:8]), .pin_c_in(lv[23:16]),
        .pin_d_in(lv[31:24]), .pin_a_out(po[7:0]), .pin_b_out(po[15:8]),
        .pin_c_out(po[23:16]), .pin_d_out(po[31:24]), .pin_a_oe(pe[7:0]),
        .pin_b_oe(pe[15:8]), .pin_c_oe(pe[23:16]), .pin_d_oe(pe[31:24]),
        .gla_out_a(lg[7:0]), .gla_out_b(lg[15:8]), .gla_out_c(lg[23:16]),
        .dla_cs_d(lg[31:24]), .la_oe_a(lo[7:0]), .la_oe_b(lo[15:8]),
        .la_oe_c(lo[23:16]), .la_oe_d(lo[31:24]), .la_sel_a(ls[7:0]),
        .la_sel_b(ls[15:8]), .la_sel_c(ls[23:16]), .la_sel_d(ls[31:24]),
        .la_in_a(li[7:0]), .la_in_b(li[15:8]), .la_in_c(li[23:16]),
        .la_in_d(li[31:24]));
    always #4 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            errors++;
            close_out();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // no wait count assumed; only the cycle ceiling ends a stuck access
    task automatic apb(input logic w, input logic [7:0] i, d);
        @(posedge pclk);
        {psel, pwrite} <= {1'h1, w};
        paddr <= {2'h0, i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic t_reset;
        repeat (12) @(posedge pclk);
        chk("oe c in reset", 32'h9c, {24'h0, pe[23:16]});
        chk("oe b in reset", 32'h0, {24'h0, pe[15:8]});
        presetn <= 1'h1;
        lo <= 32'h0;
        $display("reset test done");
    endtask : t_reset
    task automatic t_regs;
        for (int k = 0; k < 7; k++)
        begin
            apb(1'h0, ix[k], 8'h0);
            chk("reset value", 32'h0, rd);
            apb(1'h1, ix[k], 8'hff);
            apb(1'h0, ix[k], 8'h0);
            chk("readback", {24'h0, mk[k]}, rd);
        end
        apb(1'h0, 8'h3f, 8'h0);
        chk("unmapped slverr", 32'h1, {31'h0, er});
        $display("register test done");
    endtask : t_regs
    task automatic t_drive;
        apb(1'h1, PPLR_IDX_B_OUT, 8'h5a);
        chk("pin b old", 32'hff, {24'h0, po[15:8]});
        @(posedge pclk);
        chk("pin b new", 32'h5a, {24'h0, po[15:8]});
        apb(1'h0, PPLR_IDX_B_IN, 8'h0);
        chk("read b", 32'h5a, rd);
        ext <= 32'h0000c300;
        apb(1'h1, PPLR_IDX_B_DIR, 8'h0f);
        @(posedge pclk);
        chk("oe b", 32'h0f, {24'h0, pe[15:8]});
        chk("oe c", 32'h9c, {24'h0, pe[23:16]});
        chk("oe d", 32'h06, {24'h0, pe[31:24]});
        apb(1'h0, PPLR_IDX_B_IN, 8'h0);
        chk("read mixed b", 32'hca, rd);
        $display("drive test done");
    endtask : t_drive
    task automatic t_array;
        ls <= 32'h0600f000;
        lg <= 32'h04003000;
        lo <= 32'h00008000;
        apb(1'h1, PPLR_IDX_B_OUT, 8'h0);
        @(posedge pclk);
        chk("array b", 32'h30, {24'h0, po[15:8]});
        chk("oe or", 32'h8f, {24'h0, pe[15:8]});
        chk("cs d", 32'h04, {24'h0, po[31:24] & 8'h06});
        ext <= 32'h0;
        @(posedge pclk);
        chk("in d", 32'h04, {24'h0, li[31:24]});
        chk("in b old", 32'h40, {24'h0, li[15:8]});
        @(posedge pclk);
        chk("in b new", 32'h0, {24'h0, li[15:8]});
        $display("array test done");
    endtask : t_array
    task automatic t_ports;
        {ls, lg, lo} <= '0;
        ext <= 32'hf9630000;
        apb(1'h1, PPLR_IDX_A_OUT, 8'ha5);
        apb(1'h1, PPLR_IDX_C_OUT, 8'h84);
        apb(1'h0, PPLR_IDX_A_IN, 8'h0);
        chk("read a", 32'ha5, rd);
        chk("pin a", 32'ha5, {24'h0, po[7:0]});
        chk("oe a", 32'hff, {24'h0, pe[7:0]});
        chk("pin c", 32'h84, {24'h0, po[23:16]});
        chk("pready", 32'h1, {31'h0, pready});
        apb(1'h0, PPLR_IDX_C_IN, 8'h0);
        chk("read c", 32'h84, rd);
        apb(1'h0, PPLR_IDX_D_IN, 8'h0);
        chk("read d", 32'h06, rd);
        chk("good no err", 32'h0, {31'h0, er});
        chk("in a", 32'ha5, {24'h0, li[7:0]});
        chk("in c", 32'he7, {24'h0, li[23:16]});
        $display("ports test done");
    endtask : t_ports
    task automatic t_refused;
        pstrb <= 4'h0;
        apb(1'h1, PPLR_IDX_B_OUT, 8'hff);
        pstrb <= 4'h1;
        apb(1'h1, PPLR_IDX_B_IN, 8'hff);
        chk("in write no err", 32'h0, {31'h0, er});
        apb(1'h1, 8'h3f, 8'hff);
        chk("unmapped write err", 32'h1, {31'h0, er});
        apb(1'h0, PPLR_IDX_B_OUT, 8'h0);
        chk("strobe off kept", 32'h0, rd);
        apb(1'h0, PPLR_IDX_B_DIR, 8'h0);
        chk("dir kept", 32'h0f, rd);
        $display("refused test done");
    endtask : t_refused
    task automatic t_rst_mid;
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        chk("oe in reset", 32'h0, pe);
        chk("out in reset", 32'h0, po);
        chk("array in reset", 32'h0, {8'h0, li[23:0]});
        chk("prdata in reset", 32'h0, prdata);
        presetn <= 1'h1;
        apb(1'h0, PPLR_IDX_B_DIR, 8'h0);
        chk("dir after reset", 32'h0, rd);
        apb(1'h0, PPLR_IDX_C_OUT, 8'h0);
        chk("data after reset", 32'h0, rd);
        $display("mid-run reset test done");
    endtask : t_rst_mid
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {ext, lg, ls} = '0;
        pstrb = 4'h1;
        lo = 32'h00ff0000;
        t_reset();
        t_regs();
        t_drive();
        t_array();
        t_ports();
        t_refused();
        t_rst_mid();
        close_out();
    end
endmodule : pplr_bench
